//--- src/cam_unit.sv
// CPU address map unit: three zone map sets, fixed fallback, AXI4-Lite
`timescale 1ns/10ps
`default_nettype none

module cam_unit #(
    parameter int AXI_AW = 8
) (
    // Clock and reset
    input  wire logic              CLOCK_I,
    input  wire logic              NRST_I,
    // Processor request and translated result
    input  wire cam_pkg::cam_req_s CPU_REQ_I,
    output var  cam_pkg::cam_xlt_s XLT_O,
    output logic                   IRQ_O,
    // AXI4-Lite write address and data
    input  wire logic [AXI_AW-1:0] AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    // AXI4-Lite read
    input  wire logic [AXI_AW-1:0] ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [31:0]            RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I
);
    import cam_pkg::*;

    // Register index to byte offset
    function automatic logic [7:0] reg_ofs(input logic [4:0] idx);
        logic [7:0] s;
        logic [7:0] r;
        s = 8'(idx / 5'(SET_REGS));
        r = 8'(idx % 5'(SET_REGS));
        if (idx < 5'(NMAP)) begin
            reg_ofs = 8'(s * SET_STRIDE) + BIAS1_OFS + 8'(r * 8'h04);
        end else begin
            reg_ofs = CTRL_OFS + 8'((idx - 5'(NMAP)) * 5'h04);
        end
    endfunction

    // Byte address to {hit, index}; low two address bits are ignored
    function automatic logic [5:0] reg_dec(input logic [7:0] a);
        reg_dec = 6'h00;
        for (int i = 0; i < NREG; i++) begin
            if (reg_ofs(5'(i)) == {a[7:2], 2'b00}) begin
                reg_dec = {1'b1, 5'(i)};
            end
        end
    endfunction

    // Byte-lane merge of a write into the current value
    function automatic logic [31:0] lane_merge(input logic [31:0] cur,
                                               input logic [31:0] nw,
                                               input logic [3:0]  st);
        lane_merge = cur;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                lane_merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    // Zone base plus word offset, closed over the bus space
    function automatic logic [BUS_AW-1:0] relocate(
        input logic [BIAS_W-1:0] bias,
        input logic [CPU_AW-2:0] word);
        logic [BUS_AW-1:0] base;
        base     = {bias, 4'h0};
        relocate = base + BUS_AW'(word);
    endfunction

    // Register storage
    logic [BIAS_W-1:0] map_ff [0:NMAP-1];
    logic [2:0]        ctrl_ff;
    logic [ST_W-1:0]   stat_ff;
    logic [ST_W-1:0]   mask_ff;
    logic [17:0]       vadr_ff;
    cam_xlt_s          xlt_ff;
    logic              irq_ff;

    // Bus handshake state
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [31:0]       rdata_ff;
    logic [7:0]        waddr_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;

    // Register read view
    logic [31:0]       view [0:NREG-1];
    always_comb begin
        for (int i = 0; i < NMAP; i++) begin
            view[i] = 32'(map_ff[i]);
        end
        view[CTRL_IDX] = 32'(ctrl_ff);
        view[STAT_IDX] = 32'(stat_ff);
        view[MASK_IDX] = 32'(mask_ff);
        view[VADR_IDX] = 32'(vadr_ff);
    end

    // Map set selection
    wire logic [1:0] cfg_set  = ctrl_ff[CTRL_SET_LO +: 2];
    wire logic [1:0] user_set = (cfg_set == 2'h3) ? USER_TASK_MAP_SET
                                                  : cfg_set;
    wire logic       use_mon  = CPU_REQ_I.intr
                              | CPU_REQ_I.extended_operation_trap;
    wire logic [1:0] act_set  = use_mon ? MONITOR_MAP_SET
                              : CPU_REQ_I.long_dist ? LONG_DISTANCE_MAP_SET
                              : user_set;
    wire logic [4:0] set_base = 5'(act_set) * 5'(SET_REGS);
    wire logic       map_en   = ctrl_ff[CTRL_EN_BIT];

    // Zone tests on the upper 11 address bits
    wire logic [CPU_AW-1:0] cpu_a = CPU_REQ_I.addr;
    wire logic [LIM_W-1:0]  blk   = cpu_a[CPU_AW-1 -: LIM_W];
    wire logic [CPU_AW-2:0] word  = cpu_a[CPU_AW-1:1];
    wire logic [LIM_W-1:0]  lim1  = map_ff[set_base + 5'h03][LIM_W-1:0];
    wire logic [LIM_W-1:0]  lim2  = map_ff[set_base + 5'h04][LIM_W-1:0];
    wire logic [LIM_W-1:0]  lim3  = map_ff[set_base + 5'h05][LIM_W-1:0];
    wire logic [2:0]        pass  = {blk <= lim3,
                                     blk <= lim2,
                                     blk <= lim1};
    // First passing test picks the zone
    wire logic [1:0]        zone  = pass[0] ? 2'h1
                                  : pass[1] ? 2'h2
                                  : pass[2] ? 2'h3
                                  : 2'h0;
    wire logic              miss  = (pass == 3'b000);
    // The relative offset is the full word address, so zone 2 lands at
    // bias 2 plus the words below it; biases stay free in any order
    wire logic [BIAS_W-1:0] zbias = map_ff[set_base + 5'(zone)
                                           - 5'h01];
    wire logic [BUS_AW-1:0] mapped = relocate(zbias, word);

    // Fixed translation and the monitor's reserved window
    wire logic hi_win  = cpu_a >= FIX_PCS_START;
    wire logic rom_win = cpu_a >= FIX_ROM_START;
    wire logic [BUS_AW-1:0] fixed = hi_win
                                  ? FIX_PCS_BASE + BUS_AW'(word[8:0])
                                  : BUS_AW'(word);
    wire logic fix_use = !map_en
                       || (act_set == MONITOR_MAP_SET && hi_win);
    wire logic viol    = CPU_REQ_I.valid && !fix_use && miss;

    // Next translation result, one cycle after the request
    cam_xlt_s nxt_xlt;
    always_comb begin
        nxt_xlt       = '0;
        nxt_xlt.valid = CPU_REQ_I.valid && !viol;
        nxt_xlt.trap  = viol;
        // Set and zone stay zero on idle cycles so the result reads zero
        nxt_xlt.set   = CPU_REQ_I.valid ? act_set : 2'h0;
        nxt_xlt.rom   = CPU_REQ_I.valid && fix_use && rom_win;
        nxt_xlt.zone  = (CPU_REQ_I.valid && !fix_use) ? zone : 2'h0;
        if (CPU_REQ_I.valid && !viol && !nxt_xlt.rom) begin
            nxt_xlt.addr = fix_use ? fixed : mapped;
        end
    end

    // Write path: address and data are taken in either order
    wire logic       aw_take  = AWVALID_I && awready_ff;
    wire logic       w_take   = WVALID_I && wready_ff;
    wire logic       aw_have  = !awready_ff && !bvalid_ff;
    wire logic       w_have   = !wready_ff && !bvalid_ff;
    wire logic       wr_go    = aw_have && w_have;
    wire logic [5:0] wr_dec   = reg_dec(waddr_ff);
    wire logic       wr_hit   = wr_dec[5];
    wire logic [4:0] wr_idx   = wr_dec[4:0];
    wire logic [31:0] wr_val  = lane_merge(view[wr_idx], wdata_ff,
                                           wstrb_ff);
    wire logic       wr_lim   = wr_idx % 5'(SET_REGS) >= 5'h03;
    wire logic       b_done   = bvalid_ff && BREADY_I;

    // Read path
    wire logic       ar_take  = ARVALID_I && arready_ff;
    wire logic [5:0] rd_dec   = reg_dec(ARADDR_I[7:0]);
    wire logic       r_done   = rvalid_ff && RREADY_I;
    wire logic       st_clr   = ar_take && rd_dec == {1'b1, STAT_IDX};

    // Sticky events; a new event wins over the clearing read
    wire logic [ST_W-1:0] st_set = {viol && act_set
                                     == LONG_DISTANCE_MAP_SET, viol};
    wire logic [ST_W-1:0] nxt_stat = (st_clr ? '0 : stat_ff) | st_set;

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            waddr_ff   <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (aw_take) begin
                awready_ff <= 1'b0;
                waddr_ff   <= 8'(AWADDR_I);
            end
            if (w_take) begin
                wready_ff <= 1'b0;
                wdata_ff  <= WDATA_I;
                wstrb_ff  <= WSTRB_I;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_done) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            if (ar_take) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rresp_ff   <= rd_dec[5] ? RESP_OKAY : RESP_SLVERR;
                rdata_ff   <= rd_dec[5] ? view[rd_dec[4:0]]
                                        : 32'h0000_0000;
            end
            if (r_done) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // Map, control and mask registers; status is read-only
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < NMAP; i++) begin
                map_ff[i] <= '0;
            end
            ctrl_ff <= CTRL_RST;
            mask_ff <= '0;
        end else if (wr_go && wr_hit) begin
            if (wr_idx < 5'(NMAP)) begin
                map_ff[wr_idx] <= wr_lim ? 16'(wr_val[LIM_W-1:0])
                                         : wr_val[BIAS_W-1:0];
            end else if (wr_idx == CTRL_IDX) begin
                ctrl_ff <= wr_val[2:0];
            end else if (wr_idx == MASK_IDX) begin
                mask_ff <= wr_val[ST_W-1:0];
            end
        end
    end

    // Translation result, trap capture and interrupt
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            xlt_ff  <= '0;
            stat_ff <= '0;
            vadr_ff <= '0;
            irq_ff  <= 1'b0;
        end else begin
            xlt_ff  <= nxt_xlt;
            stat_ff <= nxt_stat;
            irq_ff  <= |(nxt_stat & mask_ff);
            if (viol) begin
                vadr_ff <= {act_set, cpu_a};
            end
        end
    end

    assign XLT_O     = xlt_ff;
    assign IRQ_O     = irq_ff;
    assign AWREADY_O = awready_ff;
    assign WREADY_O  = wready_ff;
    assign BVALID_O  = bvalid_ff;
    assign BRESP_O   = bresp_ff;
    assign ARREADY_O = arready_ff;
    assign RVALID_O  = rvalid_ff;
    assign RRESP_O   = rresp_ff;
    assign RDATA_O   = rdata_ff;

endmodule

`default_nettype wire

//--- src/cam_pkg.sv
// Constants, register map and carrier types of the CPU address map unit
package cam_pkg;
    // Processor and bus address widths, field widths and map counts
    localparam int CPU_AW   = 16;
    localparam int BUS_AW   = 20;
    localparam int BIAS_W   = 16;
    localparam int LIM_W    = 11;
    localparam int NSETS    = 3;
    localparam int NZONES   = 3;
    localparam int SET_REGS = 6;
    localparam int NMAP     = 18;
    localparam int NREG     = 22;
    // Bias steps in 16-word units
    localparam int BIAS_SHIFT = 4;
    // Fixed translation: direct words below, control space, then ROM
    localparam logic [15:0] FIX_PCS_START = 16'hf800;
    localparam logic [15:0] FIX_ROM_START = 16'hfc00;
    localparam logic [19:0] FIX_PCS_BASE  = 20'hffc00;
    // Register byte offsets
    localparam logic [7:0] SET_STRIDE = 8'h20;
    localparam logic [7:0] BIAS1_OFS  = 8'h00;
    localparam logic [7:0] LIMIT1_OFS = 8'h0c;
    localparam logic [7:0] CTRL_OFS   = 8'h60;
    localparam logic [7:0] STAT_OFS   = 8'h64;
    localparam logic [7:0] MASK_OFS   = 8'h68;
    localparam logic [7:0] VADR_OFS   = 8'h6c;
    // Register indices beyond the map registers
    localparam logic [4:0] CTRL_IDX = 5'h12;
    localparam logic [4:0] STAT_IDX = 5'h13;
    localparam logic [4:0] MASK_IDX = 5'h14;
    localparam logic [4:0] VADR_IDX = 5'h15;
    // Control fields and reset value
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SET_LO = 1;
    localparam logic [2:0] CTRL_RST = 3'h2;
    // Status fields
    localparam int ST_VIOL = 0;
    localparam int ST_LONG = 1;
    localparam int ST_W    = 2;
    // Map set numbers
    localparam logic [1:0] MONITOR_MAP_SET       = 2'h0;
    localparam logic [1:0] USER_TASK_MAP_SET     = 2'h1;
    localparam logic [1:0] LONG_DISTANCE_MAP_SET = 2'h2;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              valid;
        logic [CPU_AW-1:0] addr;
        logic              intr;
        logic              extended_operation_trap;
        logic              long_dist;
    } cam_req_s;

    typedef struct packed {
        logic              valid;
        logic              rom;
        logic              trap;
        logic [1:0]        zone;
        logic [1:0]        set;
        logic [BUS_AW-1:0] addr;
    } cam_xlt_s;
endpackage

//--- testbench/cam_unit_sva.sv
// Port-level assertions for the address map unit
`timescale 1ns/10ps
`default_nettype none
module cam_unit_sva (
    // Clock and reset
    input wire logic              CLOCK_I,
    input wire logic              NRST_I,
    // Translation
    input wire cam_pkg::cam_req_s CPU_REQ_I,
    input wire cam_pkg::cam_xlt_s XLT_O,
    // Register bus
    input wire logic              AWVALID_I,
    input wire logic              AWREADY_O,
    input wire logic              WVALID_I,
    input wire logic              WREADY_O,
    input wire logic              BVALID_O,
    input wire logic              ARVALID_I,
    input wire logic              ARREADY_O,
    input wire logic              RVALID_O
);
    import cam_pkg::*;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    a_idle_zero: assert property (
        !CPU_REQ_I.valid |=> XLT_O == '0)
        else $error("result with no request");
    a_req_answer: assert property (
        CPU_REQ_I.valid |=> XLT_O.valid || XLT_O.trap || XLT_O.rom)
        else $error("request left unanswered");
    a_trap_no_bus: assert property (
        XLT_O.trap |-> !XLT_O.valid && XLT_O.addr == '0)
        else $error("trap issued a bus access");
    a_intr_monitor_set: assert property (
        CPU_REQ_I.valid && (CPU_REQ_I.intr || CPU_REQ_I.extended_operation_trap)
        |=> XLT_O.set == MONITOR_MAP_SET)
        else $error("trap entry not on monitor set");
    a_long_dist_set: assert property (
        CPU_REQ_I.valid && CPU_REQ_I.long_dist && !CPU_REQ_I.intr
        && !CPU_REQ_I.extended_operation_trap
        |=> XLT_O.set == LONG_DISTANCE_MAP_SET)
        else $error("long access not on set 2");
    a_rom_no_bus: assert property (
        XLT_O.rom |-> XLT_O.addr == '0 && !XLT_O.trap)
        else $error("rom access carries an address");
    a_b_latency: assert property (
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
        else $error("write response late");
    a_r_after_ar: assert property (
        ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
        else $error("read answer late");
endmodule
bind cam_unit cam_unit_sva u_sva (.CLOCK_I, .NRST_I, .CPU_REQ_I, .XLT_O,
    .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BVALID_O,
    .ARVALID_I, .ARREADY_O, .RVALID_O);
`default_nettype wire

//--- testbench/cam_cpu_model.sv
// Processor core stand-in issuing one translation request at a time
`timescale 1ns/10ps
`default_nettype none
module cam_cpu_model (
    // Clock
    input  wire logic              clk_i,
    // Request toward the map unit
    output var  cam_pkg::cam_req_s req_o
);
    import cam_pkg::*;
    initial req_o = '0;
    // Flags are intr, extended operation trap, long distance
    task automatic issue(input logic [15:0] a, input logic [2:0] f);
        @(posedge clk_i);
        req_o <= {1'b1, a, f};
        @(posedge clk_i);
        // Idle cycles show a scrambled address, not the last one
        req_o <= {1'b0, ~a, 3'b000};
    endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Register and translation tests of the address map unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cam_pkg::*;
    logic clk = 0, nrst = 0, irq;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    cam_req_s req;
    cam_xlt_s xlt;
    int failures = 0, checked = 0;
    localparam logic [26:0] MA = 27'h7ffffff;
    // Set field is not compared where the fixed path or a trap answers
    localparam logic [26:0] MF = 27'h7cfffff;
    localparam logic [26:0] MR = 27'h3cfffff;
    localparam logic [26:0] MT = 27'h50fffff;
    always #50 clk = ~clk;
    cam_cpu_model cpu (.clk_i(clk), .req_o(req));
    cam_unit dut (.CLOCK_I(clk), .NRST_I(nrst), .CPU_REQ_I(req), .XLT_O(xlt),
        .IRQ_O(irq), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
        .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string s);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid && n < 50);
        bready <= 0;
        if (n >= 50) begin
            $display("[ERR] %0t write timeout", $time);
            failures++;
            tally_and_finish();
        end else chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "write resp");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid && n < 50);
        rready <= 0;
        if (n >= 50) begin
            $display("[ERR] %0t read timeout", $time);
            failures++;
            tally_and_finish();
        end else begin
            chk(rdata, e, "read data");
            chk({30'h0, rresp}, {30'h0, er}, "read resp");
        end
    endtask
    task automatic xl(input logic [15:0] a, input logic [2:0] f,
                      input logic [26:0] e, input logic [26:0] m);
        cpu.issue(a, f);
        #1 chk({5'h0, xlt & m}, {5'h0, e}, "translation");
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, {31'h0, e}, "interrupt");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        rd(8'h60, 32'h2, RESP_OKAY);
        rd(8'h28, 32'h0, RESP_OKAY);
        rd(8'h70, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'hffff1000);
        rd(8'h20, 32'h1000, RESP_OKAY);
        wr(8'h2c, 32'hfffff80f);
        rd(8'h2c, 32'h00f, RESP_OKAY);
        $display("register test done");
        xl(16'h1234, 3'b000, {7'h40, 20'h0091a}, MF);
        xl(16'hf7fe, 3'b000, {7'h40, 20'h07bff}, MF);
        xl(16'hf802, 3'b000, {7'h40, 20'hffc01}, MF);
        xl(16'hfc00, 3'b000, {7'h20, 20'h0}, MR);
        $display("fixed test done");
        wr(8'h24, 32'h0100);
        wr(8'h28, 32'hfff0);
        wr(8'h30, 32'h01f);
        wr(8'h34, 32'h02f);
        wr(8'h60, 32'h3);
        xl(16'h0000, 3'b000, {7'h45, 20'h10000}, MA);
        xl(16'h01fe, 3'b000, {7'h45, 20'h100ff}, MA);
        xl(16'h0200, 3'b000, {7'h49, 20'h01100}, MA);
        xl(16'h0400, 3'b000, {7'h4d, 20'h00100}, MA);
        wr(8'h68, 32'h1);
        xl(16'h0600, 3'b000, {7'h10, 20'h0}, MT);
        irq_is(1'b1);
        rd(8'h6c, 32'h10600, RESP_OKAY);
        rd(8'h64, 32'h1, RESP_OKAY);
        irq_is(1'b0);
        rd(8'h64, 32'h0, RESP_OKAY);
        $display("zone test done");
        xl(16'h0010, 3'b100, {7'h44, 20'h00008}, MA);
        xl(16'h0002, 3'b101, {7'h44, 20'h00001}, MA);
        xl(16'hf802, 3'b010, {7'h40, 20'hffc01}, MF);
        xl(16'hfc02, 3'b010, {7'h20, 20'h0}, MR);
        wr(8'h40, 32'h0200);
        xl(16'h0002, 3'b001, {7'h46, 20'h02001}, MA);
        wr(8'h68, 32'h0);
        xl(16'h0600, 3'b000, {7'h10, 20'h0}, MT);
        irq_is(1'b0);
        rd(8'h64, 32'h1, RESP_OKAY);
        xl(16'h0040, 3'b001, {7'h10, 20'h0}, MT);
        rd(8'h64, 32'h3, RESP_OKAY);
        wr(8'h60, 32'h5);
        xl(16'h0002, 3'b000, {7'h46, 20'h02001}, MA);
        wr(8'h60, 32'h7);
        xl(16'h0000, 3'b000, {7'h45, 20'h10000}, MA);
        wr(8'h60, 32'h2);
        xl(16'h0400, 3'b000, {7'h40, 20'h00200}, MF);
        $display("map set test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
